/* File: guard_interlock_defines.vh */
// Purpose : constants of the guard interlock controller
// Assumes : 250 MHz clock, 4 ns period
// Notes   : times in their own unit, cycle counts derived from them
`ifndef GUARD_INTERLOCK_DEFINES_VH
`define GUARD_INTERLOCK_DEFINES_VH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define CLK_MHZ            250

// ----------------------------------------------------------------------
// times as printed
// ----------------------------------------------------------------------
`define TEACH_WAIT_S       10
`define POWEROFF_WAIT_MIN  5
`define INHIBIT_MIN        10
`define ACT_LOSS_MS        100
`define INPUT_DROP_US      1500
`define SLOW_FLASH_HZ      1
`define FAST_FLASH_HZ      3
`define WRONG_ACT_PULSES   5

// ----------------------------------------------------------------------
// derived cycle counts (defaults of top parameters, except INPUT_DROP_CYC and ACT_LOSS_CYC)
// ----------------------------------------------------------------------
// sized base count: minute counts overflow 32-bit integer arithmetic
`define CYC_PER_S          (38'h00000f4240 * `CLK_MHZ)
`define TEACH_WAIT_CYC     (`TEACH_WAIT_S * `CYC_PER_S)
`define POWEROFF_WAIT_CYC  (`POWEROFF_WAIT_MIN * 60 * `CYC_PER_S)
`define INHIBIT_CYC        (`INHIBIT_MIN * 60 * `CYC_PER_S)
`define SLOW_HALF_CYC      (`CYC_PER_S / (2 * `SLOW_FLASH_HZ))
`define FAST_HALF_CYC      (`CYC_PER_S / (2 * `FAST_FLASH_HZ))
`define INPUT_DROP_CYC     (`INPUT_DROP_US * `CLK_MHZ)
`define ACT_LOSS_CYC       (`ACT_LOSS_MS * 1000 * `CLK_MHZ)

// ----------------------------------------------------------------------
// counter width, wide enough for ten minutes
// ----------------------------------------------------------------------
`define CNT_W              38

`endif

/* File: sync_bit.v */
// Purpose : two flip-flop synchroniser for one pin
// Assumes : input is asynchronous to clk_i
// Notes   : first stage feeds only the second stage
`timescale 1ns/1ps
module sync_bit
(
   input  wire clk_i,    // system clock
   input  wire rst_b_i,  // async reset, active low
   input  wire d_i,      // asynchronous pin
   output reg  q_o       // synchronised level
);
   reg meta;

   // ---------------------------------------------------------------
   // two stage capture
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

/* File: guard_interlock_controller.v */
// Purpose : teach-in, LED signalling and safety output control
// Assumes : one clock, power-up reset, code memory kept outside
// Notes   : store strobe goes to nonvolatile memory; the stored code
//           and flags come back as inputs after every power-up
`timescale 1ns/1ps
`include "guard_interlock_defines.vh"
module guard_interlock_controller
#(
   parameter [`CNT_W-1:0] TEACH_WAIT  = `TEACH_WAIT_CYC,    // 10 s
   parameter [`CNT_W-1:0] POWEROFF_WT = `POWEROFF_WAIT_CYC, // 5 min
   parameter [`CNT_W-1:0] INHIBIT     = `INHIBIT_CYC,       // 10 min
   parameter [`CNT_W-1:0] SLOW_HALF   = `SLOW_HALF_CYC,     // 1 Hz half
   parameter [`CNT_W-1:0] FAST_HALF   = `FAST_HALF_CYC      // 3 Hz half
)
(
   input  wire        clk_i,                 // system clock
   input  wire        rst_b_i,               // power-up reset, low
   input  wire        safety_input_a_i,      // safety channel a pin
   input  wire        safety_input_b_i,      // safety channel b pin
   input  wire        actuator_present_i,    // coded actuator in range
   input  wire [15:0] actuator_code_i,       // code read from actuator
   input  wire        guard_closed_i,        // guard door closed
   input  wire        guard_locked_i,        // bolt in locked state
   input  wire        lock_cmd_i,            // solenoid control: lock
   input  wire        handle_between_i,      // handle not at pos 1/2
   input  wire        emergency_exit_i,      // exit lever actuated
   input  wire        emergency_release_i,   // release lever actuated
   input  wire        manual_release_off_i,  // manual release not at 0
   input  wire        single_teach_variant_i,// one pairing only
   input  wire        multi_teach_variant_i, // unlimited teach-in
   input  wire        lock_monitor_i,        // 1 lock, 0 door monitor
   input  wire [15:0] stored_code_i,         // code held in memory
   input  wire        code_valid_i,          // stored code is usable
   input  wire        pending_valid_i,       // learned, awaits confirm
   input  wire [15:0] pending_code_i,        // learned code awaiting
   input  wire        inhibit_pend_i,        // inhibit owed at power-up
   output reg         safety_output_a_o,     // safety channel a
   output reg         safety_output_b_o,     // safety channel b
   output reg         lock_drive_o,          // solenoid lock drive
   output reg         led_power_o,           // green LED
   output reg         led_fault_o,           // red LED
   output reg         led_status_o,          // yellow LED
   output reg         store_o,               // memory write strobe
   output reg  [15:0] store_code_o,          // code to write
   output reg         store_valid_o,         // value of valid flag
   output reg         store_pending_o,       // value of pending flag
   output reg         store_inhibit_o        // value of inhibit flag
);
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [5:0] ST_RUN   = 6'h01;
   localparam [5:0] ST_TEACH = 6'h02;
   localparam [5:0] ST_OFFRQ = 6'h04;
   localparam [5:0] ST_ABORT = 6'h08;
   localparam [5:0] ST_CONF  = 6'h10;
   localparam [5:0] ST_INH   = 6'h20;

   reg  [5:0]        state;
   reg  [5:0]        next_state;
   reg  [`CNT_W-1:0] tmr;
   reg  [`CNT_W-1:0] blink;
   reg               slow_ph;
   reg               fast_ph;
   reg  [3:0]        pulse_cnt;
   reg               boot;
   wire              in_a;
   wire              in_b;
   wire              teach_var;
   wire              code_ok;
   wire              guard_ok;
   wire              lock_block;
   wire              pend_ok;
   reg               enable;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   sync_bit u_sync_a
   (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     (safety_input_a_i),
      .q_o     (in_a)
   );

   sync_bit u_sync_b
   (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     (safety_input_b_i),
      .q_o     (in_b)
   );

   // ---------------------------------------------------------------
   // actuator acceptance
   // ---------------------------------------------------------------
   assign teach_var = single_teach_variant_i | multi_teach_variant_i;
   // standard coding takes any actuator of the right type
   assign code_ok = actuator_present_i &
                    (!teach_var |
                     (code_valid_i &
                      (actuator_code_i == stored_code_i)));

   // guard condition per monitoring variant
   assign guard_ok = lock_monitor_i ?
                     (guard_closed_i & guard_locked_i) :
                     guard_closed_i;

   // any of these keeps the bolt from engaging
   assign lock_block = handle_between_i |
                       emergency_exit_i |
                       manual_release_off_i;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always @*
   begin
      next_state = state;
      case (state)
         ST_RUN:
         begin
            // unknown actuator seen; taken up again after an abort
            if (teach_var & actuator_present_i & !code_ok &
                !(single_teach_variant_i & code_valid_i))
               next_state = ST_TEACH;
         end
         ST_TEACH:
            if (tmr >= TEACH_WAIT - 1'b1)
               next_state = ST_OFFRQ;
         ST_OFFRQ:
            // waits for the supply to go; the reset ends the wait
            if (tmr >= POWEROFF_WT - 1'b1)
               next_state = ST_ABORT;
         ST_ABORT:
            // back to normal once the last red pulse has ended
            if (pulse_cnt == `WRONG_ACT_PULSES & !slow_ph)
               next_state = ST_RUN;
         ST_CONF:
            // the new code must be seen, not the old stored one
            if (tmr >= INHIBIT - 1'b1 & pend_ok)
               next_state = ST_RUN;
         ST_INH:
            // one cycle so the inhibit count starts from zero
            next_state = ST_CONF;
         default:
            next_state = ST_RUN;
      endcase
   end

   // ---------------------------------------------------------------
   // state, timers, power-up bookkeeping
   // ---------------------------------------------------------------
   // the memory write of teach and confirm happens once per event;
   // losing power at any point leaves memory consistent
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state           <= ST_RUN;
         tmr             <= {`CNT_W{1'b0}};
         boot            <= 1'b1;
         store_o         <= 1'b0;
         store_code_o    <= 16'h0000;
         store_valid_o   <= 1'b0;
         store_pending_o <= 1'b0;
         store_inhibit_o <= 1'b0;
      end
      else
      begin
         store_o <= 1'b0;
         if (boot)
         begin
            boot <= 1'b0;
            // learned code waits for the actuator after power-up
            if (teach_var & pending_valid_i)
               state <= ST_INH;
         end
         else
            state <= next_state;
         tmr <= (next_state != state || boot) ? {`CNT_W{1'b0}} :
                tmr + 1'b1;
         // code learned; stored only as pending until confirmed
         if (state == ST_TEACH && next_state == ST_OFFRQ)
         begin
            store_o         <= 1'b1;
            store_code_o    <= actuator_code_i;
            // old code voided at once, it must not open the guard again
            store_valid_o   <= 1'b0;
            store_pending_o <= 1'b1;
            store_inhibit_o <= multi_teach_variant_i;
         end
         // confirmation: new code replaces the old one, written only
         // at the end, so a power loss during the inhibit leaves the
         // pending flag set and the next power-up restarts it
         if (state == ST_CONF && next_state == ST_RUN)
         begin
            store_o         <= 1'b1;
            store_code_o    <= pending_code_i;
            store_valid_o   <= 1'b1;
            store_pending_o <= 1'b0;
            store_inhibit_o <= 1'b0;
         end
      end
   end

   // actuator matches the code awaiting confirmation; a net, so the
   // next-state process sees every signal it depends on
   assign pend_ok = actuator_present_i &
                    (actuator_code_i == pending_code_i);

   // ---------------------------------------------------------------
   // blink generators, 1 Hz and 3 Hz, plus red pulse counter
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         blink     <= {`CNT_W{1'b0}};
         slow_ph   <= 1'b0;
         fast_ph   <= 1'b0;
         pulse_cnt <= 4'h0;
      end
      else
      begin
         // one free-running counter serves both flash rates
         blink <= blink + 1'b1;
         if (blink % SLOW_HALF == SLOW_HALF - 1'b1)
         begin
            slow_ph <= ~slow_ph;
            // count completed red pulses while aborting
            if (state != ST_ABORT)
               pulse_cnt <= 4'h0;
            else if (slow_ph && pulse_cnt != `WRONG_ACT_PULSES)
               pulse_cnt <= pulse_cnt + 4'h1;
         end
         else if (state != ST_ABORT)
            pulse_cnt <= 4'h0;
         if (blink % FAST_HALF == FAST_HALF - 1'b1)
            fast_ph <= ~fast_ph;
      end
   end

   // ---------------------------------------------------------------
   // output enable decision
   // ---------------------------------------------------------------
   // inputs pass two flops and one register: worst case 3 cycles,
   // far inside the drop limit
   // limitation: a test pulse drops both outputs for a cycle; there
   // is no pulse filter, since no filter time is fixed for the inputs
   always @*
   begin
      enable = in_a & in_b &
               code_ok &
               guard_ok &
               !emergency_exit_i & !emergency_release_i &
               (state == ST_RUN) &
               !boot;
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         safety_output_a_o <= 1'b0;
         safety_output_b_o <= 1'b0;
         lock_drive_o      <= 1'b0;
         led_power_o       <= 1'b0;
         led_fault_o       <= 1'b0;
         led_status_o      <= 1'b0;
      end
      else
      begin
         // one enable drives both channels together
         safety_output_a_o <= enable;
         safety_output_b_o <= enable;
         lock_drive_o      <= lock_cmd_i & guard_closed_i &
                              !lock_block;
         case (state)
            ST_TEACH:
            begin
               led_power_o  <= 1'b0;
               led_fault_o  <= 1'b1;
               led_status_o <= slow_ph;
            end
            ST_OFFRQ:
            begin
               led_power_o  <= 1'b0;
               led_fault_o  <= 1'b1;
               led_status_o <= fast_ph;
            end
            ST_ABORT:
            begin
               led_power_o  <= 1'b1;
               led_fault_o  <= slow_ph &
                               (pulse_cnt != `WRONG_ACT_PULSES);
               led_status_o <= 1'b0;
            end
            ST_CONF, ST_INH:
            begin
               led_power_o  <= slow_ph;
               led_fault_o  <= 1'b0;
               led_status_o <= 1'b0;
            end
            default:
            begin
               // slow green blink when a channel is missing
               led_power_o  <= (in_a & in_b) ? 1'b1 : slow_ph;
               led_fault_o  <= 1'b0;
               led_status_o <= guard_locked_i ? 1'b1 :
                               (guard_closed_i ? slow_ph : 1'b0);
            end
         endcase
      end
   end
endmodule

/* File: safety_monitor_model.sv */
// Purpose : safety-monitoring module driving the two safety inputs
// Assumes : levels change just after the rising edge of clk_i
// Notes   : test pulse spacing is scaled down to keep runs short
`timescale 1ns/1ps
module safety_monitor_model
#(
   parameter GAP = 400                 // pulse spacing, stands for 100 ms
)
(
   input  wire clk_i,                  // system clock
   input  wire rst_b_i,                // reset, active low
   input  wire chan_a_ok_i,            // channel a released
   input  wire chan_b_ok_i,            // channel b released
   input  wire pulse_en_i,             // test pulses wanted
   output reg  chan_a_o,               // to safety_input_a
   output reg  chan_b_o                // to safety_input_b
);
   reg [15:0] gap_cnt;

   // one-cycle dark pulses, each channel at most once per gap, offset
   // by half a gap so the two channels are never tested together
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         gap_cnt  <= 16'h0000;
         chan_a_o <= 1'b0;
         chan_b_o <= 1'b0;
      end
      else
      begin
         gap_cnt  <= (gap_cnt == GAP - 1) ? 16'h0000 : gap_cnt + 16'h0001;
         chan_a_o <= chan_a_ok_i && !(pulse_en_i && gap_cnt == 0);
         chan_b_o <= chan_b_ok_i && !(pulse_en_i && gap_cnt == GAP / 2);
      end
   end
endmodule

/* File: guard_interlock_controller_chk.sv */
// Purpose : port assertions of the guard interlock controller
// Assumes : bound to every controller instance
// Notes   : bounds leave room for the two-flop input synchroniser
`timescale 1ns/1ps
module guard_interlock_chk
(
   input wire clk_i,                   // system clock
   input wire rst_b_i,                 // reset, active low
   input wire safety_input_a_i,        // channel a pin
   input wire safety_input_b_i,        // channel b pin
   input wire actuator_present_i,      // actuator in range
   input wire guard_closed_i,          // guard closed
   input wire guard_locked_i,          // bolt locked
   input wire emergency_exit_i,        // exit lever
   input wire emergency_release_i,     // release lever
   input wire handle_between_i,        // handle off its positions
   input wire manual_release_off_i,    // manual release off home
   input wire lock_monitor_i,          // lock or door monitoring
   input wire safety_output_a_o,       // channel a out
   input wire safety_output_b_o,       // channel b out
   input wire lock_drive_o             // solenoid drive
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // ---------------------------------------------------------------
   // switch-off paths
   // ---------------------------------------------------------------
   AST_CHAN_PAIR:
      assert property (safety_output_a_o == safety_output_b_o)
      else $error("safety channels differ");
   AST_INPUT_DROP:
      assert property (!(safety_input_a_i && safety_input_b_i)
         |-> ##[1:4] !safety_output_a_o)
      else $error("outputs stay on after input drop");
   AST_ACT_LOSS:
      assert property (!actuator_present_i |-> ##[1:2] !safety_output_a_o)
      else $error("outputs stay on without actuator");
   AST_EMERG_OFF:
      assert property ($rose(emergency_exit_i || emergency_release_i)
         |-> ##[1:3] !safety_output_b_o)
      else $error("outputs stay on after emergency lever");
   AST_UNLOCK_OFF:
      assert property (lock_monitor_i && !guard_locked_i
         |-> ##[1:3] !safety_output_a_o)
      else $error("outputs stay on while unlocked");
   AST_OPEN_OFF:
      assert property ((!lock_monitor_i && !guard_closed_i)[*2]
         |-> !safety_output_b_o)
      else $error("outputs stay on with guard open");

   // ---------------------------------------------------------------
   // locking and enable causes
   // ---------------------------------------------------------------
   AST_LOCK_BLOCK:
      assert property ((handle_between_i || emergency_exit_i
         || manual_release_off_i) |-> ##[1:3] !lock_drive_o)
      else $error("locking while blocked");
   AST_ENABLE_CAUSE:
      assert property ($rose(safety_output_a_o)
         |-> $past(actuator_present_i) && !$past(emergency_exit_i))
      else $error("outputs enabled without cause");
endmodule

bind guard_interlock_controller guard_interlock_chk guard_interlock_chk_inst
(
   .clk_i, .rst_b_i, .safety_input_a_i, .safety_input_b_i,
   .actuator_present_i, .guard_closed_i, .guard_locked_i,
   .emergency_exit_i, .emergency_release_i, .handle_between_i,
   .manual_release_off_i, .lock_monitor_i, .safety_output_a_o,
   .safety_output_b_o, .lock_drive_o
);

/* File: guard_interlock_controller_tb_top.sv */
// Purpose : self-checking bench of the guard interlock controller
// Assumes : short timer parameters, memory inputs changed in reset
// Notes   : flash rates checked by counting rises over two periods
`timescale 1ns/1ps
module guard_interlock_controller_tb_top;
   reg         clk_i, rst_b, act, closed, locked, lcmd, handle, ex, rel;
   reg         man, st1, mt, lmon, cval, pval, ipend, a_ok, b_ok, pen;
   reg  [15:0] code, scode, pcode, st_code;
   reg         st_val, st_pend, st_inh, p_st, p_fa, p_pw;
   integer     n_errors, n_tests, n_store, r_st, r_fa, r_pw, n0;
   wire        sa, sb, oa, ob, lk, lp, lf, ls, so, sv, sp, si;
   wire [15:0] sc;

   guard_interlock_controller #(.TEACH_WAIT(40), .POWEROFF_WT(80),
      .INHIBIT(100), .SLOW_HALF(4), .FAST_HALF(2))
   guard_interlock_controller_inst (.clk_i(clk_i), .rst_b_i(rst_b),
      .safety_input_a_i(sa), .safety_input_b_i(sb),
      .actuator_present_i(act), .actuator_code_i(code),
      .guard_closed_i(closed), .guard_locked_i(locked), .lock_cmd_i(lcmd),
      .handle_between_i(handle), .emergency_exit_i(ex),
      .emergency_release_i(rel), .manual_release_off_i(man),
      .single_teach_variant_i(st1), .multi_teach_variant_i(mt),
      .lock_monitor_i(lmon), .stored_code_i(scode), .code_valid_i(cval),
      .pending_valid_i(pval), .pending_code_i(pcode),
      .inhibit_pend_i(ipend), .safety_output_a_o(oa),
      .safety_output_b_o(ob), .lock_drive_o(lk), .led_power_o(lp),
      .led_fault_o(lf), .led_status_o(ls), .store_o(so),
      .store_code_o(sc), .store_valid_o(sv), .store_pending_o(sp),
      .store_inhibit_o(si));

   safety_monitor_model safety_monitor_model_inst (.clk_i(clk_i),
      .rst_b_i(rst_b), .chan_a_ok_i(a_ok), .chan_b_ok_i(b_ok),
      .pulse_en_i(pen), .chan_a_o(sa), .chan_b_o(sb));

   // clock, 4 ns period
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // store capture and led rise counters, free running across resets
   always @(posedge clk_i)
   begin
      if (so === 1'b1)
      begin
         n_store <= n_store + 1;
         st_code <= sc;
         st_val  <= sv;
         st_pend <= sp;
         st_inh  <= si;
      end
      r_st <= r_st + (ls && !p_st);
      r_fa <= r_fa + (lf && !p_fa);
      r_pw <= r_pw + (lp && !p_pw);
      p_st <= ls;
      p_fa <= lf;
      p_pw <= lp;
   end

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_i);
         #1;
      end
   endtask

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp)
         begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask

   task do_reset;
      begin
         rst_b = 1'b0;
         tick(8);
         rst_b = 1'b1;
      end
   endtask

   // bounded wait for the next memory write strobe
   task wait_store(input integer lim);
      integer i, m;
      begin
         m = n_store;
         for (i = 0; i < lim && n_store == m; i = i + 1)
            tick(1);
         chk(n_store == m, 1'b0);
         if (n_store == m)
            wrap_up;
      end
   endtask

   task wrap_up;
      begin
         $display("tests %0d errors %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      {n_errors, n_tests, n_store, r_st, r_fa, r_pw} = 0;
      {p_st, p_fa, p_pw, rst_b, handle, ex, rel, man, st1, mt, pen} = 0;
      {act, closed, locked, lcmd, lmon, a_ok, b_ok} = 7'h7f;
      {cval, pval, ipend} = 3'h0;
      {code, scode, pcode} = 48'h0;
      do_reset;
      tick(6);
      chk({oa, ob}, 2'b11);
      a_ok = 1'b0; tick(4); chk(oa, 1'b0);
      a_ok = 1'b1; tick(6); chk(ob, 1'b1);
      act = 1'b0; tick(2); chk(oa, 1'b0);
      act = 1'b1; ex = 1'b1; tick(3); chk({oa, lk}, 2'b00);
      ex = 1'b0; rel = 1'b1; tick(3); chk(ob, 1'b0);
      rel = 1'b0; man = 1'b1; tick(3); chk(lk, 1'b0);
      man = 1'b0; tick(3); chk(lk, 1'b1);
      handle = 1'b1; tick(3); chk(lk, 1'b0);
      handle = 1'b0; locked = 1'b0; tick(3); chk(oa, 1'b0);
      locked = 1'b1; tick(4); chk(oa, 1'b1);
      lmon = 1'b0; do_reset; tick(6);
      locked = 1'b0; tick(4); chk(oa, 1'b1);
      closed = 1'b0; tick(3); chk(oa, 1'b0);
      // multi-teach: unknown actuator starts teach-in with test pulses on
      {closed, locked, lmon, mt, cval, pen} = 6'h3f;
      scode = 16'h1234; code = 16'h5678;
      do_reset; tick(4);
      chk({lp, lf}, 2'b01);
      n0 = r_st; tick(16); chk(r_st - n0, 2);
      wait_store(60);
      chk({st_pend, st_val, st_inh, st_code}, {3'b101, 16'h5678});
      tick(2); n0 = r_st; tick(8); chk(r_st - n0, 2);
      tick(60); act = 1'b0; n0 = r_fa;
      tick(200); chk(r_fa - n0, 5);
      chk(oa, 1'b0);
      // power-up with learned code owed its inhibit
      {act, pen, cval, pval, ipend} = 5'h13;
      pcode = 16'h5678;
      do_reset; n0 = r_pw; tick(20);
      chk(oa, 1'b0);
      chk(r_pw == n0, 1'b0);
      tick(40); n0 = n_store; do_reset; tick(90);
      chk(ob, 1'b0);
      chk(n_store - n0, 0);
      wait_store(60);
      chk({st_val, st_pend, st_inh, st_code}, {3'b100, 16'h5678});
      // single-teach with a pairing already made refuses a new actuator
      {pval, ipend, mt, st1, cval} = 5'h03;
      do_reset; n0 = n_store; tick(150);
      chk(n_store - n0, 0);
      chk(oa, 1'b0);
      wrap_up;
   end
endmodule
